// ===== rtl/adcr_regs.v
// Function
// - first loudness filter gain compensation only while 0x0E bit 6 set.
// - 0x26 holds signed 3.23 reciprocal gain in bits 25..0.
// - 0x28 holds 3.23 loudness scale in bits 25..0.
// - 0x46 bit 0 turns satellite range compressor on; off by default.
// - 0x46 bit 1 turns subchannel range compressor on; off by default.
// - bits 2 and 3 couple satellite detection to channels 3 and 4.
// - 0x50 bits 2..0 select live, bank 1..3 or automatic target.
// - 0x50 bit 6 enables headphone range compression.
// - 0x50 bit 7 enables headphone equalization.
// - 0x19 bits 5..0 mark channels 6..1 in the shutdown group.
// - 0x1A bit 7 selects single-ended load operation.
// - 0x1A bits 4..0 set the start/stop ramp period.
// - 0x20 per-channel bit selects three-level modulation when one.
// - 0x20 bits 29..24 invert audio of channels 6..1.
// - three-bit source field selects input or constant zero.
// - channel 5 source code 111 takes inverse of channel 6.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/10ps
`include "adcr_defs.vh"

module adcr_regs (
	input  wire        i_clock,
	input  wire        i_rstn,
	input  wire        i_wb_cyc,
	input  wire        i_wb_stb,
	input  wire        i_wb_we,
	input  wire [9:0]  i_wb_adr,
	input  wire [3:0]  i_wb_sel,
	input  wire [31:0] i_wb_dat,
	output reg  [31:0] o_wb_dat,
	output reg         o_wb_ack,
	output reg         o_wb_err,
	output reg         o_gain_comp_en,
	output reg  [25:0] o_loudness_gain_recip,
	output reg  [25:0] o_loudness_scale,
	output reg         o_sat_drc_en,
	output reg         o_sub_drc_en,
	output reg         o_sat_drc_dep_ch3,
	output reg         o_sat_drc_dep_ch4,
	output reg  [2:0]  o_bank_target,
	output reg         o_bank_auto,
	output reg         o_hp_drc_en,
	output reg         o_hp_eq_en,
	output reg  [5:0]  o_shutdown_group,
	output reg         o_single_ended_load,
	output reg  [4:0]  o_ramp_period,
	output reg  [5:0]  o_three_level,
	output reg  [5:0]  o_invert,
	output reg  [17:0] o_source_sel,
	output reg  [5:0]  o_source_zero,
	output reg         o_ch5_bridge
);

// ====================================================================
// registers
reg [7:0]  volume_config;
reg [7:0]  shutdown_group_membership;
reg [7:0]  start_stop_period;
reg [31:0] input_routing_modulation;
reg [31:0] loudness_gain_reciprocal;
reg [31:0] loudness_scale;
reg [7:0]  range_compressor_control;
reg [7:0]  bank_switch_headphone_ctl;

// ====================================================================
// bus decode
function [3:0] adcr_decode;
	input [9:0] adr;
	begin
		case (adr)
		{`ADCR_IDX_VOLCFG, 2'h0}:    adcr_decode = 4'h1;
		{`ADCR_IDX_SDGROUP, 2'h0}:   adcr_decode = 4'h2;
		{`ADCR_IDX_STARTSTOP, 2'h0}: adcr_decode = 4'h3;
		{`ADCR_IDX_INMUX, 2'h0}:     adcr_decode = 4'h4;
		{`ADCR_IDX_LGAININV, 2'h0}:  adcr_decode = 4'h5;
		{`ADCR_IDX_LSCALE, 2'h0}:    adcr_decode = 4'h6;
		{`ADCR_IDX_RANGECTL, 2'h0}:  adcr_decode = 4'h7;
		{`ADCR_IDX_BANKSW, 2'h0}:    adcr_decode = 4'h8;
		default:                     adcr_decode = 4'h0;
		endcase
	end
endfunction

// byte-lane merge, masked so reserved bits stay zero
function [31:0] adcr_merge;
	input [31:0] old;
	input [31:0] wdat;
	input [3:0]  sel;
	input [31:0] mask;
	integer k;
	begin
		adcr_merge = old;
		for (k = 0; k < 4; k = k + 1) begin
			if (sel[k])
				adcr_merge[k*8 +: 8] = wdat[k*8 +: 8];
		end
		adcr_merge = adcr_merge & mask;
	end
endfunction

wire       req = i_wb_cyc & i_wb_stb & ~o_wb_ack & ~o_wb_err;
wire [3:0] sel_reg = adcr_decode(i_wb_adr);
wire       wr = req & i_wb_we & (sel_reg != 4'h0);

reg [31:0] next_rdata;
always @* begin
	case (sel_reg)
	4'h1:    next_rdata = {24'h000000, volume_config};
	4'h2:    next_rdata = {24'h000000, shutdown_group_membership};
	4'h3:    next_rdata = {24'h000000, start_stop_period};
	4'h4:    next_rdata = input_routing_modulation;
	4'h5:    next_rdata = loudness_gain_reciprocal;
	4'h6:    next_rdata = loudness_scale;
	4'h7:    next_rdata = {24'h000000, range_compressor_control};
	4'h8:    next_rdata = {24'h000000, bank_switch_headphone_ctl};
	default: next_rdata = 32'h00000000;
	endcase
end

// ack one cycle after request; unmapped addresses answer with err
always @(posedge i_clock or negedge i_rstn) begin
	if (!i_rstn) begin
		o_wb_ack <= 1'b0;
	end else begin
		o_wb_ack <= req & (sel_reg != 4'h0);
	end
end

// err instead of ack keeps a stray access from looking like a write
always @(posedge i_clock or negedge i_rstn) begin
	if (!i_rstn) begin
		o_wb_err <= 1'b0;
	end else begin
		o_wb_err <= req & (sel_reg == 4'h0);
	end
end

// read data holds until the next request, so a slow master still sees it
always @(posedge i_clock or negedge i_rstn) begin
	if (!i_rstn) begin
		o_wb_dat <= 32'h00000000;
	end else if (req) begin
		o_wb_dat <= next_rdata;
	end
end

// ====================================================================
// write masks: reserved bits are never stored, so they read back zero
function [31:0] adcr_mask;
	input [3:0] s;
	begin
		case (s)
		4'h1:    adcr_mask = {24'h000000, `ADCR_MASK_VOLCFG};
		4'h2:    adcr_mask = {24'h000000, `ADCR_MASK_SDGROUP};
		4'h3:    adcr_mask = {24'h000000, `ADCR_MASK_STARTSTOP};
		4'h4:    adcr_mask = `ADCR_MASK_INMUX;
		4'h5:    adcr_mask = `ADCR_MASK_FIX;
		4'h6:    adcr_mask = `ADCR_MASK_FIX;
		4'h7:    adcr_mask = {24'h000000, `ADCR_MASK_RANGECTL};
		4'h8:    adcr_mask = {24'h000000, `ADCR_MASK_BANKSW};
		default: adcr_mask = 32'h00000000;
		endcase
	end
endfunction

// old word comes from the read mux, so one merger serves every register
wire [31:0] wr_mask = adcr_mask(sel_reg);
wire [31:0] merged  = adcr_merge(next_rdata, i_wb_dat, i_wb_sel, wr_mask);
wire        wr_vol  = wr & (sel_reg == 4'h1);
wire        wr_sdg  = wr & (sel_reg == 4'h2);
wire        wr_ss   = wr & (sel_reg == 4'h3);
wire        wr_mux  = wr & (sel_reg == 4'h4);
wire        wr_ginv = wr & (sel_reg == 4'h5);
wire        wr_scl  = wr & (sel_reg == 4'h6);
wire        wr_rc   = wr & (sel_reg == 4'h7);
wire        wr_bs   = wr & (sel_reg == 4'h8);

// ====================================================================
// register writes, one flop group per register
// volume config keeps only the compensation enable
always @(posedge i_clock or negedge i_rstn) begin
	if (!i_rstn) begin
		volume_config <= `ADCR_RST_VOLCFG;
	end else if (wr_vol) begin
		volume_config <= merged[7:0];
	end
end

// shutdown group membership
always @(posedge i_clock or negedge i_rstn) begin
	if (!i_rstn) begin
		shutdown_group_membership <= `ADCR_RST_SDGROUP;
	end else if (wr_sdg) begin
		shutdown_group_membership <= merged[7:0];
	end
end

// start/stop period and load type
always @(posedge i_clock or negedge i_rstn) begin
	if (!i_rstn) begin
		start_stop_period <= `ADCR_RST_STARTSTOP;
	end else if (wr_ss) begin
		start_stop_period <= merged[7:0];
	end
end

// input routing and modulation
always @(posedge i_clock or negedge i_rstn) begin
	if (!i_rstn) begin
		input_routing_modulation <= `ADCR_RST_INMUX;
	end else if (wr_mux) begin
		input_routing_modulation <= merged;
	end
end

// reciprocal gain, bits 25..0 stored as written; the filter interprets it
always @(posedge i_clock or negedge i_rstn) begin
	if (!i_rstn) begin
		loudness_gain_reciprocal <= `ADCR_RST_FIX;
	end else if (wr_ginv) begin
		loudness_gain_reciprocal <= merged;
	end
end

// loudness scale
always @(posedge i_clock or negedge i_rstn) begin
	if (!i_rstn) begin
		loudness_scale <= `ADCR_RST_FIX;
	end else if (wr_scl) begin
		loudness_scale <= merged;
	end
end

// range compressor enables and coupling
always @(posedge i_clock or negedge i_rstn) begin
	if (!i_rstn) begin
		range_compressor_control <= `ADCR_RST_RANGECTL;
	end else if (wr_rc) begin
		range_compressor_control <= merged[7:0];
	end
end

// bank switch and headphone enables
always @(posedge i_clock or negedge i_rstn) begin
	if (!i_rstn) begin
		bank_switch_headphone_ctl <= `ADCR_RST_BANKSW;
	end else if (wr_bs) begin
		bank_switch_headphone_ctl <= merged[7:0];
	end
end

// ====================================================================
// decoded controls, registered so every output is a flip-flop
wire [31:0] mux = input_routing_modulation;
wire [2:0]  bank_code = bank_switch_headphone_ctl[2:0];
wire [5:0]  next_three_level;
wire [17:0] next_source_sel;
wire [5:0]  next_source_zero;
wire [5:0]  next_invert;

// channel n (1..6) field sits at nibble 6-n: bit3 mode, bits2..0 source
genvar ch;
generate
	for (ch = 0; ch < 6; ch = ch + 1) begin : g_mode
		assign next_three_level[ch] = mux[(5-ch)*4 + 3];
	end
endgenerate

generate
	for (ch = 0; ch < 6; ch = ch + 1) begin : g_src
		assign next_source_sel[ch*3 +: 3] = mux[(5-ch)*4 +: 3];
	end
endgenerate

// a zero source silences the channel, whatever its other settings
generate
	for (ch = 0; ch < 6; ch = ch + 1) begin : g_zero
		assign next_source_zero[ch] =
			(mux[(5-ch)*4 +: 3] == `ADCR_SRC_ZERO);
	end
endgenerate

// invert bits run upward from channel 1, unlike the source fields
generate
	for (ch = 0; ch < 6; ch = ch + 1) begin : g_inv
		assign next_invert[ch] = mux[24 + ch];
	end
endgenerate

// ====================================================================
// loudness controls
always @(posedge i_clock or negedge i_rstn) begin
	if (!i_rstn) begin
		o_gain_comp_en        <= 1'b0;
		o_loudness_gain_recip <= 26'h0000000;
		o_loudness_scale      <= 26'h0000000;
	end else begin
		o_gain_comp_en <= volume_config[`ADCR_VOL_GCOMP_BIT];
		o_loudness_gain_recip <= loudness_gain_reciprocal[25:0];
		o_loudness_scale <= loudness_scale[25:0];
	end
end

// ====================================================================
// range compressor controls
always @(posedge i_clock or negedge i_rstn) begin
	if (!i_rstn) begin
		o_sat_drc_en      <= 1'b0;
		o_sub_drc_en      <= 1'b0;
		o_sat_drc_dep_ch3 <= 1'b0;
		o_sat_drc_dep_ch4 <= 1'b0;
	end else begin
		o_sat_drc_en <= range_compressor_control[`ADCR_RC_SAT_BIT];
		o_sub_drc_en <= range_compressor_control[`ADCR_RC_SUB_BIT];
		o_sat_drc_dep_ch3 <= range_compressor_control[`ADCR_RC_CH3_BIT];
		o_sat_drc_dep_ch4 <= range_compressor_control[`ADCR_RC_CH4_BIT];
	end
end

// ====================================================================
// bank target and headphone processing
always @(posedge i_clock or negedge i_rstn) begin
	if (!i_rstn) begin
		o_bank_target <= 3'h0;
		o_bank_auto   <= 1'b0;
		o_hp_drc_en   <= 1'b0;
		o_hp_eq_en    <= 1'b0;
	end else begin
		// codes above automatic are treated as live updates
		if (bank_code <= `ADCR_BANK_3)
			o_bank_target <= bank_code;
		else
			o_bank_target <= `ADCR_BANK_LIVE;
		o_bank_auto <= (bank_code == `ADCR_BANK_AUTO);
		o_hp_drc_en <= bank_switch_headphone_ctl[`ADCR_BS_HPDRC_BIT];
		o_hp_eq_en <= bank_switch_headphone_ctl[`ADCR_BS_HPEQ_BIT];
	end
end

// ====================================================================
// shutdown group and start/stop
always @(posedge i_clock or negedge i_rstn) begin
	if (!i_rstn) begin
		o_shutdown_group    <= 6'h00;
		o_single_ended_load <= 1'b0;
		o_ramp_period       <= 5'h00;
	end else begin
		o_shutdown_group <= shutdown_group_membership[5:0];
		o_single_ended_load <= start_stop_period[`ADCR_SS_SE_BIT];
		o_ramp_period <= start_stop_period[4:0];
	end
end

// ====================================================================
// channel routing, inversion and modulation
always @(posedge i_clock or negedge i_rstn) begin
	if (!i_rstn) begin
		o_three_level <= 6'h00;
		o_invert      <= 6'h00;
		o_source_sel  <= 18'h00000;
		o_source_zero <= 6'h00;
		o_ch5_bridge  <= 1'b0;
	end else begin
		o_three_level <= next_three_level;
		o_invert <= next_invert;
		o_source_sel <= next_source_sel;
		o_source_zero <= next_source_zero;
		o_ch5_bridge <= (mux[6:4] == `ADCR_SRC_BRIDGE);
	end
end

endmodule

// ===== shared/adcr_defs.vh
`ifndef ADCR_DEFS_VH
`define ADCR_DEFS_VH

// ====================================================================
// register indices (byte address is index times four)
`define ADCR_IDX_VOLCFG      8'h0E
`define ADCR_IDX_SDGROUP     8'h19
`define ADCR_IDX_STARTSTOP   8'h1A
`define ADCR_IDX_INMUX       8'h20
`define ADCR_IDX_LGAININV    8'h26
`define ADCR_IDX_LSCALE      8'h28
`define ADCR_IDX_RANGECTL    8'h46
`define ADCR_IDX_BANKSW      8'h50
`define ADCR_ADDR_W          10

// ====================================================================
// field positions
`define ADCR_VOL_GCOMP_BIT   6
`define ADCR_SS_SE_BIT       7
`define ADCR_RC_SAT_BIT      0
`define ADCR_RC_SUB_BIT      1
`define ADCR_RC_CH3_BIT      2
`define ADCR_RC_CH4_BIT      3
`define ADCR_BS_HPDRC_BIT    6
`define ADCR_BS_HPEQ_BIT     7
`define ADCR_FIX_W           26

// ====================================================================
// write masks (reserved bits stay zero)
`define ADCR_MASK_VOLCFG     8'h40
`define ADCR_MASK_SDGROUP    8'h3F
`define ADCR_MASK_STARTSTOP  8'h9F
`define ADCR_MASK_INMUX      32'h3FFFFFFF
`define ADCR_MASK_FIX        32'h03FFFFFF
`define ADCR_MASK_RANGECTL   8'h0F
`define ADCR_MASK_BANKSW     8'hC7

// ====================================================================
// reset values
`define ADCR_RST_VOLCFG      8'h00
`define ADCR_RST_SDGROUP     8'h00
`define ADCR_RST_STARTSTOP   8'h00
`define ADCR_RST_INMUX       32'h00000000
`define ADCR_RST_FIX         32'h00000000
`define ADCR_RST_RANGECTL    8'h00
`define ADCR_RST_BANKSW      8'h00

// ====================================================================
// bank target codes and source codes
`define ADCR_BANK_LIVE       3'h0
`define ADCR_BANK_1          3'h1
`define ADCR_BANK_2          3'h2
`define ADCR_BANK_3          3'h3
`define ADCR_BANK_AUTO       3'h4
`define ADCR_SRC_ZERO        3'h6
`define ADCR_SRC_BRIDGE      3'h7

`endif

// ===== verification/adcr_regs_props.sv
`timescale 1ns/10ps
module adcr_regs_props (
	input wire        i_clock,
	input wire        i_rstn,
	input wire        i_wb_cyc,
	input wire        i_wb_stb,
	input wire        i_wb_we,
	input wire [9:0]  i_wb_adr,
	input wire [3:0]  i_wb_sel,
	input wire [31:0] i_wb_dat,
	input wire        o_wb_ack,
	input wire        o_wb_err,
	input wire        o_gain_comp_en,
	input wire        o_sat_drc_en,
	input wire        o_sub_drc_en,
	input wire        o_sat_drc_dep_ch3,
	input wire        o_sat_drc_dep_ch4,
	input wire        o_bank_auto,
	input wire        o_hp_drc_en,
	input wire        o_hp_eq_en,
	input wire [5:0]  o_shutdown_group,
	input wire        o_single_ended_load,
	input wire [4:0]  o_ramp_period,
	input wire [5:0]  o_invert
);
	// ====================================================================
	// full-word writes only; the bench also drives only full-word writes
	wire wr = o_wb_ack & i_wb_we & (i_wb_sel == 4'hF);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack held too long");
	a_req_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack &&
		!o_wb_err |=> o_wb_ack ^ o_wb_err) else $error("no single answer");
	a_gain_comp: assert property (wr && i_wb_adr == 10'h038 |=>
		o_gain_comp_en == $past(i_wb_dat[6])) else $error("gain comp");
	a_range_bits: assert property (wr && i_wb_adr == 10'h118 |=>
		{o_sat_drc_dep_ch4, o_sat_drc_dep_ch3, o_sub_drc_en, o_sat_drc_en}
		== $past(i_wb_dat[3:0])) else $error("range control");
	a_bank_auto: assert property (wr && i_wb_adr == 10'h140 |=>
		o_bank_auto == ($past(i_wb_dat[2:0]) == 3'h4)) else $error("auto bank");
	a_hp_enables: assert property (wr && i_wb_adr == 10'h140 |=>
		{o_hp_eq_en, o_hp_drc_en} == $past(i_wb_dat[7:6]))
		else $error("headphone enables");
	a_group_bits: assert property (wr && i_wb_adr == 10'h064 |=>
		o_shutdown_group == $past(i_wb_dat[5:0])) else $error("group");
	a_ramp_load: assert property (wr && i_wb_adr == 10'h068 |=>
		{o_single_ended_load, o_ramp_period} == {$past(i_wb_dat[7]),
		$past(i_wb_dat[4:0])}) else $error("start stop");
	a_invert_bits: assert property (wr && i_wb_adr == 10'h080 |=>
		o_invert == $past(i_wb_dat[29:24])) else $error("invert");
	c_err: cover property (o_wb_err);
	c_bank_auto: cover property (o_bank_auto);
	c_invert: cover property (o_invert != 6'h00);
endmodule

bind adcr_regs adcr_regs_props u_adcr_regs_props (.i_clock, .i_rstn,
	.i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_ack,
	.o_wb_err, .o_gain_comp_en, .o_sat_drc_en, .o_sub_drc_en,
	.o_sat_drc_dep_ch3, .o_sat_drc_dep_ch4, .o_bank_auto, .o_hp_drc_en,
	.o_hp_eq_en, .o_shutdown_group, .o_single_ended_load, .o_ramp_period,
	.o_invert);

// ===== verification/test_audio_dap_config_regs.sv
`timescale 1ns/10ps
module test_audio_dap_config_regs;
	reg i_clock = 1'b0, i_rstn = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0;
	reg i_wb_we = 1'b0;
	reg [9:0] i_wb_adr = 10'h000;
	reg [3:0] i_wb_sel = 4'hF;
	reg [31:0] i_wb_dat = 32'h00000000;
	wire [31:0] o_wb_dat;
	wire o_wb_ack, o_wb_err, o_gain_comp_en, o_sat_drc_en, o_sub_drc_en;
	wire o_sat_drc_dep_ch3, o_sat_drc_dep_ch4, o_bank_auto, o_hp_drc_en;
	wire o_hp_eq_en, o_single_ended_load, o_ch5_bridge;
	wire [25:0] o_loudness_gain_recip, o_loudness_scale;
	wire [2:0] o_bank_target;
	wire [4:0] o_ramp_period;
	wire [5:0] o_shutdown_group, o_three_level, o_invert, o_source_zero;
	wire [17:0] o_source_sel;
	integer error_cnt = 0, compares = 0, cyc_cnt = 0, i;
	reg [31:0] rd;
	// ====================================================================
	// register map, index 0 in the low slice
	reg [69:0] adrs = {10'h140, 10'h118, 10'h0A0, 10'h098, 10'h080,
		10'h068, 10'h064};
	reg [223:0] masks = {32'hC7, 32'h0F, 32'h03FFFFFF, 32'h03FFFFFF,
		32'h3FFFFFFF, 32'h9F, 32'h3F};

	adcr_regs u_adcr_regs (.i_clock, .i_rstn, .i_wb_cyc, .i_wb_stb, .i_wb_we,
		.i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_wb_err,
		.o_gain_comp_en, .o_loudness_gain_recip, .o_loudness_scale,
		.o_sat_drc_en, .o_sub_drc_en, .o_sat_drc_dep_ch3, .o_sat_drc_dep_ch4,
		.o_bank_target, .o_bank_auto, .o_hp_drc_en, .o_hp_eq_en,
		.o_shutdown_group, .o_single_ended_load, .o_ramp_period,
		.o_three_level, .o_invert, .o_source_sel, .o_source_zero,
		.o_ch5_bridge);

	initial forever #20 i_clock = ~i_clock;

	task check(input [31:0] got, input [31:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("unexpected at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask

	// one classic cycle; answer flags checked at the edge that ends it
	task bus(input w, input [9:0] a, input [31:0] d, input e);
		integer n;
		begin
			i_wb_cyc <= 1'b1;
			i_wb_stb <= 1'b1;
			i_wb_we <= w;
			i_wb_adr <= a;
			i_wb_dat <= d;
			n = 0;
			@(posedge i_clock);
			while (!(o_wb_ack | o_wb_err) && n < 20) begin
				@(posedge i_clock);
				n = n + 1;
			end
			rd = o_wb_dat;
			check({o_wb_ack, o_wb_err}, {~e, e});
			i_wb_cyc <= 1'b0;
			i_wb_stb <= 1'b0;
			i_wb_we <= 1'b0;
			@(posedge i_clock);
		end
	endtask

	task t_access;
		begin
			for (i = 0; i < 7; i = i + 1) begin
				bus(0, adrs[i*10 +: 10], 0, 0);
				check(rd, 0);
				bus(1, adrs[i*10 +: 10], 32'hFFFFFFFF, 0);
				bus(0, adrs[i*10 +: 10], 0, 0);
				check(rd, masks[i*32 +: 32]);
				bus(1, adrs[i*10 +: 10], 0, 0);
			end
		end
	endtask

	task t_fields;
		begin
			bus(1, 10'h038, 32'h00000040, 0);
			check(o_gain_comp_en, 1);
			bus(1, 10'h038, 32'hFFFFFFBF, 0);
			check(o_gain_comp_en, 0);
			bus(1, 10'h098, 32'hFC800001, 0);
			check(o_loudness_gain_recip, 26'h0800001);
			bus(1, 10'h0A0, 32'h03FFFFFE, 0);
			check(o_loudness_scale, 26'h3FFFFFE);
			for (i = 0; i < 16; i = i + 1) begin
				bus(1, 10'h118, i, 0);
				check({o_sat_drc_dep_ch4, o_sat_drc_dep_ch3, o_sub_drc_en,
					o_sat_drc_en}, i);
			end
			for (i = 0; i < 8; i = i + 1) begin
				bus(1, 10'h140, {i[1:0], 3'h0, i[2:0]}, 0);
				check(o_bank_target, (i < 4) ? i : 0);
				check(o_bank_auto, i == 4);
				check({o_hp_eq_en, o_hp_drc_en}, i[1:0]);
			end
		end
	endtask

	task t_two_one;
		begin
			bus(1, 10'h064, 32'h0000000C, 0);
			bus(1, 10'h068, 32'h00000095, 0);
			bus(1, 10'h080, 32'h0201667A, 0);
			check(o_shutdown_group, 6'h0C);
			check(o_single_ended_load, 1);
			check(o_ramp_period, 5'h15);
			check(o_three_level, 6'h20);
			check(o_invert, 6'h02);
			check(o_source_sel, {3'h2, 3'h7, 3'h6, 3'h6, 3'h1, 3'h0});
			check(o_source_zero, 6'h0C);
			check(o_ch5_bridge, 1);
			bus(1, 10'h3FC, 32'hFFFFFFFF, 1);
			bus(0, 10'h03C, 0, 1);
			check(rd, 0);
			// mid-run reset must clear invert, shutdown group and single-ended load
			i_rstn <= 1'b0;
			repeat (2) @(posedge i_clock);
			i_rstn <= 1'b1;
			@(posedge i_clock);
			check({o_invert, o_shutdown_group, o_single_ended_load}, 0);
		end
	endtask

	task wrap_up;
		begin
			$display("errors %0d compares %0d", error_cnt, compares);
			if (error_cnt == 0 && compares > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask

	always @(posedge i_clock) begin
		cyc_cnt = cyc_cnt + 1;
		if (cyc_cnt == 3000) begin
			error_cnt = error_cnt + 1;
			wrap_up;
		end
	end

	initial begin
		repeat (6) @(posedge i_clock);
		i_rstn <= 1'b1;
		@(posedge i_clock);
		t_access;
		t_fields;
		t_two_one;
		wrap_up;
	end
endmodule
